// *** core/sadc_pkg.sv ***
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sadc_pkg;
   localparam int        RES_W        = 12;       // result width
   localparam int        NCH          = 8;        // single-ended channels
   localparam int        NDIFF        = 4;        // differential pairs
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_SCAN   = 2'h1;
   localparam logic [1:0] MODE_CONT   = 2'h3;
   localparam logic [1:0] CH7_EXT     = 2'h0;     // external analog input
   localparam logic [1:0] CH7_BGAP    = 2'h1;     // bandgap reference
   localparam logic [1:0] CH7_TEMP    = 2'h2;     // temperature sensor
   localparam logic [1:0] CH7_AGND    = 2'h3;     // analog ground
   localparam int        CLK_KHZ      = 20000;    // system clock rate
   localparam int        ADC_MAX_KHZ  = 16000;    // ceiling on converter clock
   localparam int        CONV_TIME_NS = 1250;     // longest conversion time
   localparam int        CONV_MAX_CYC = CONV_TIME_NS * CLK_KHZ / 1000000;
   localparam logic [2:0] SAMPLE_CYC  = 3'h4;     // sample phase length
   localparam logic [5:0] CAL_CYC     = 6'h20;    // calibration length
   localparam logic [3:0] MSB_IDX     = 4'hb;
   localparam logic [11:0] RES_RST    = 12'h000;
   typedef enum logic [2:0] {S_IDLE, S_CAL, S_SAMPLE, S_CONV, S_STORE} sadc_state_e;
endpackage : sadc_pkg

// *** core/sadc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl
   import sadc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   // software control
   input  wire logic [1:0]        mode,
   input  wire logic              start_wr,
   input  wire logic              start_clr,
   output logic                   conversion_start_bit,
   input  wire logic              ext_trig_en,
   input  wire logic              external_trigger_pin,
   input  wire logic [NCH-1:0]    chan_en,
   input  wire logic [2:0]        single_chan,
   input  wire logic              diff_mode,
   input  wire logic [1:0]        ch7_src,
   input  wire logic              cmp_en,
   input  wire logic [RES_W-1:0]  cmp_val,
   input  wire logic              cmp_clr,
   output logic                   cmp_flag,
   input  wire logic              done_clr,
   output logic                   conv_done,
   input  wire logic              cal_req,
   output logic                   cal_busy,
   output logic                   busy,
   // result read port
   input  wire logic              rd_en,
   input  wire logic [2:0]        rd_chan,
   output logic [RES_W-1:0]       rd_data,
   output logic                   rd_valid,
   output logic                   rd_ovr,
   // analog core side
   output logic [2:0]             mux_chan,
   output logic                   mux_diff,
   output logic [1:0]             mux_ch7_sel,
   output logic                   sample_hold,
   output logic [RES_W-1:0]       dac_code,
   input  wire logic              cmp_hi,
   output logic                   cal_mode
);
   //---------------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------------
   // lowest enabled channel at or above from; msb says one was found
   function automatic logic [3:0] find_chan(input logic [NCH-1:0] en,
                                            input logic [3:0] from);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (en[i] && (4'(i) >= from)) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction : find_chan

   //---------------------------------------------------------------------------
   // trigger pin synchroniser
   //---------------------------------------------------------------------------
   logic trig_s1_r, trig_s2_r, trig_s3_r;
   logic trig_rise;

   // two flops then an edge detector on the second
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_s3_r <= 1'b0;
      end else begin
         trig_s1_r <= external_trigger_pin;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
      end
   end
   assign trig_rise = ext_trig_en & trig_s2_r & ~trig_s3_r;

   //---------------------------------------------------------------------------
   // sequencer
   //---------------------------------------------------------------------------
   sadc_state_e      state_r, state_nxt;
   logic             start_r, start_nxt;
   logic             done_r, done_nxt;
   logic [2:0]       chan_r, chan_nxt;
   logic [5:0]       cnt_r, cnt_nxt;
   logic [3:0]       bit_r, bit_nxt;
   logic [RES_W-1:0] code_r, code_nxt;
   logic [NCH-1:0]   eff_en;
   logic [3:0]       first_ch, next_ch;
   logic             store;

   assign eff_en   = diff_mode ? (chan_en & 8'h0f) : chan_en;
   assign first_ch = find_chan(eff_en, 4'h0);
   assign next_ch  = find_chan(eff_en, 4'({1'b0, chan_r}) + 4'h1);
   assign store    = (state_r == S_STORE);

   // next state of the conversion sequencer
   always_comb begin
      state_nxt = state_r;
      start_nxt = start_r;
      done_nxt  = done_r;
      chan_nxt  = chan_r;
      cnt_nxt   = cnt_r;
      bit_nxt   = bit_r;
      code_nxt  = code_r;
      if (start_clr) begin
         start_nxt = 1'b0;
      end
      if (done_clr) begin
         done_nxt = 1'b0;
      end
      case (state_r)
         S_IDLE: begin
            if (cal_req) begin
               state_nxt = S_CAL;
               cnt_nxt   = 6'h0;
            end else if (start_r) begin
               cnt_nxt = 6'h0;
               if (mode == MODE_SINGLE) begin
                  chan_nxt  = diff_mode ? {1'b0, single_chan[1:0]} : single_chan;
                  state_nxt = S_SAMPLE;
               end else if (first_ch[3]) begin
                  chan_nxt  = first_ch[2:0];
                  state_nxt = S_SAMPLE;
               end else begin
                  start_nxt = 1'b0;                                // nothing enabled
               end
            end
         end
         S_CAL: begin
            cnt_nxt = cnt_r + 6'h1;
            if (cnt_r == CAL_CYC - 6'h1) begin
               state_nxt = S_IDLE;
            end
         end
         S_SAMPLE: begin
            cnt_nxt = cnt_r + 6'h1;
            if (cnt_r[2:0] == SAMPLE_CYC - 3'h1) begin
               state_nxt = S_CONV;
               bit_nxt   = MSB_IDX;
               code_nxt  = 12'h800;                                // first trial
            end
         end
         S_CONV: begin
            // keep trial bit when input is at or above the dac level
            if (!cmp_hi) begin
               code_nxt[bit_r] = 1'b0;
            end
            if (bit_r == 4'h0) begin
               state_nxt = S_STORE;
            end else begin
               bit_nxt = bit_r - 4'h1;
               code_nxt[bit_r - 4'h1] = 1'b1;
            end
         end
         S_STORE: begin
            cnt_nxt = 6'h0;
            if (mode == MODE_SINGLE) begin
               state_nxt = S_IDLE;
               start_nxt = 1'b0;
               done_nxt  = 1'b1;
            end else if (next_ch[3]) begin
               chan_nxt  = next_ch[2:0];
               state_nxt = S_SAMPLE;
            end else if (mode == MODE_CONT && start_nxt && first_ch[3]) begin
               chan_nxt  = first_ch[2:0];
               state_nxt = S_SAMPLE;
            end else begin
               state_nxt = S_IDLE;
               if (mode != MODE_CONT) begin
                  start_nxt = 1'b0;
                  done_nxt  = 1'b1;
               end
            end
         end
         default: state_nxt = S_IDLE;
      endcase
      // a new start outranks the auto clear and a software clear
      if (start_wr || trig_rise) begin
         start_nxt = 1'b1;
      end
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         start_r <= 1'b0;
         done_r  <= 1'b0;
         chan_r  <= 3'h0;
         cnt_r   <= 6'h0;
         bit_r   <= 4'h0;
         code_r  <= RES_RST;
      end else begin
         state_r <= state_nxt;
         start_r <= start_nxt;
         done_r  <= done_nxt;
         chan_r  <= chan_nxt;
         cnt_r   <= cnt_nxt;
         bit_r   <= bit_nxt;
         code_r  <= code_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // result registers and compare
   //---------------------------------------------------------------------------
   logic [RES_W-1:0] res_r [NCH], res_nxt [NCH];
   logic [NCH-1:0]   valid_r, valid_nxt, ovr_r, ovr_nxt;
   logic             cmpf_r, cmpf_nxt;
   logic [RES_W-1:0] rdd_r, rdd_nxt;
   logic             rdv_r, rdv_nxt, rdo_r, rdo_nxt;

   // store, read-clear and compare; a store beats a read clear
   always_comb begin
      res_nxt   = res_r;
      valid_nxt = valid_r;
      ovr_nxt   = ovr_r;
      cmpf_nxt  = cmpf_r;
      rdd_nxt   = rdd_r;
      rdv_nxt   = rdv_r;
      rdo_nxt   = rdo_r;
      if (rd_en) begin
         rdd_nxt            = res_r[rd_chan];
         rdv_nxt            = valid_r[rd_chan];
         rdo_nxt            = ovr_r[rd_chan];
         valid_nxt[rd_chan] = 1'b0;
         ovr_nxt[rd_chan]   = 1'b0;
      end
      if (cmp_clr) begin
         cmpf_nxt = 1'b0;
      end
      if (store) begin
         res_nxt[chan_r]   = code_r;
         valid_nxt[chan_r] = 1'b1;
         if (valid_r[chan_r]) begin
            ovr_nxt[chan_r] = 1'b1;
         end
         if (cmp_en && code_r == cmp_val) begin
            cmpf_nxt = 1'b1;
         end
      end
   end

   // result registers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            res_r[i] <= RES_RST;
         end
         valid_r <= 8'h00;
         ovr_r   <= 8'h00;
         cmpf_r  <= 1'b0;
         rdd_r   <= RES_RST;
         rdv_r   <= 1'b0;
         rdo_r   <= 1'b0;
      end else begin
         res_r   <= res_nxt;
         valid_r <= valid_nxt;
         ovr_r   <= ovr_nxt;
         cmpf_r  <= cmpf_nxt;
         rdd_r   <= rdd_nxt;
         rdv_r   <= rdv_nxt;
         rdo_r   <= rdo_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------------------
   assign conversion_start_bit = start_r;
   assign conv_done   = done_r;
   assign cmp_flag    = cmpf_r;
   assign cal_busy    = (state_r == S_CAL);
   assign cal_mode    = (state_r == S_CAL);
   assign busy        = (state_r != S_IDLE);
   assign rd_data     = rdd_r;
   assign rd_valid    = rdv_r;
   assign rd_ovr      = rdo_r;
   assign mux_chan    = chan_r;
   assign mux_diff    = diff_mode;
   assign mux_ch7_sel = ch7_src;
   assign sample_hold = (state_r == S_SAMPLE);
   assign dac_code    = code_r;

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   localparam int CONV_MAX = 24;

   sequence s_sample_start;
      $rose(sample_hold);
   endsequence
   sequence s_stored;
      ##[1:CONV_MAX] store;
   endsequence

   property p_conv_time;
      @(posedge clk) disable iff (rst) s_sample_start |-> s_stored;
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion too long");

   property p_single_stop;
      @(posedge clk) disable iff (rst)
         (store && mode == MODE_SINGLE && !start_wr && !trig_rise)
            |=> (state_r == S_IDLE && !start_r && done_r);
   endproperty
   a_single_stop: assert property (p_single_stop) else $error("single mode did not stop");

   property p_scan_up;
      @(posedge clk) disable iff (rst)
         (store && mode == MODE_SCAN && next_ch[3]) |=> (chan_r > $past(chan_r));
   endproperty
   a_scan_up: assert property (p_scan_up) else $error("scan not ascending");

   property p_scan_end;
      @(posedge clk) disable iff (rst)
         (store && mode == MODE_SCAN && !next_ch[3] && !start_wr && !trig_rise)
            |=> (!start_r && done_r && state_r == S_IDLE);
   endproperty
   a_scan_end: assert property (p_scan_end) else $error("scan end not flagged");

   property p_start;
      @(posedge clk) disable iff (rst)
         (start_wr && state_r == S_IDLE && !cal_req && mode == MODE_SINGLE)
            |=> start_r ##1 sample_hold;
   endproperty
   a_start: assert property (p_start) else $error("start write ignored");

   property p_trig;
      @(posedge clk) disable iff (rst) trig_rise |=> start_r;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger ignored");

   property p_valid;
      @(posedge clk) disable iff (rst)
         store |=> (valid_r[$past(chan_r)] && res_r[$past(chan_r)] == $past(code_r));
   endproperty
   a_valid: assert property (p_valid) else $error("result not stored");

   property p_ovr;
      @(posedge clk) disable iff (rst) (store && valid_r[chan_r]) |=> ovr_r[$past(chan_r)];
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun missed");

   property p_cmp;
      @(posedge clk) disable iff (rst)
         (store && cmp_en && code_r == cmp_val) |=> cmp_flag;
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare match missed");

   property p_cal;
      @(posedge clk) disable iff (rst) (state_r == S_IDLE && cal_req) |=> cal_mode [*8];
   endproperty
   a_cal: assert property (p_cal) else $error("calibration too short");

   property p_diff;
      @(posedge clk) disable iff (rst) (busy && diff_mode) |-> (mux_chan < 3'h4);
   endproperty
   a_diff: assert property (p_diff) else $error("differential channel out of range");
endmodule : sadc_ctrl
`default_nettype wire

// *** sim/sadc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// analog core model: mux, sample and hold, sar comparator
//------------------------------------------------------------
module sadc_core_model
   import sadc_pkg::*;
#(
   parameter logic [RES_W-1:0] BG = 12'h5a0,   // bandgap code, plain default
   parameter logic [RES_W-1:0] TP = 12'h3c3    // sensor code, plain default
)
(
   input  wire logic                        clk,
   input  wire logic [NCH-1:0][RES_W-1:0]   volt,
   input  wire logic [2:0]                  mux_chan,
   input  wire logic                        mux_diff,
   input  wire logic [1:0]                  mux_ch7_sel,
   input  wire logic                        sample_hold,
   input  wire logic [RES_W-1:0]            dac_code,
   output logic                             cmp_hi
);
   logic [RES_W-1:0] pick;
   logic [RES_W-1:0] held = 12'h000;
   logic             tog  = 1'b0;
   // input selection, pairs use the low channel of each pair
   always_comb begin
      if (mux_diff) pick = volt[{1'b0, mux_chan[1:0]}];
      else if (mux_chan != 3'h7 || mux_ch7_sel == CH7_EXT) pick = volt[mux_chan];
      else if (mux_ch7_sel == CH7_BGAP) pick = BG;
      else if (mux_ch7_sel == CH7_TEMP) pick = TP;
      else pick = 12'h000;
   end
   // hold the input while sampling; junk output while tracking
   always @(posedge clk) begin
      if (sample_hold) held <= pick;
      tog <= ~tog;
   end
   assign cmp_hi = sample_hold ? tog : (held >= dac_code);
endmodule : sadc_core_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// testbench
//------------------------------------------------------------
module testbench
   import sadc_pkg::*;
;
   localparam logic [11:0] BG = 12'h5a0;
   localparam logic [11:0] TP = 12'h3c3;
   logic clk = 0, rst = 1, ext_trig_en = 0, diff_mode = 0, cmp_en = 0, rd_en = 0;
   logic [1:0] mode = 0, ch7_src = 0;
   logic [2:0] single_chan = 0, rd_chan = 0;
   logic [5:0] pls = 0;
   logic [7:0] chan_en = 0, en;
   logic [11:0] cmp_val = 0;
   logic [NCH-1:0][RES_W-1:0] volt = '0;
   logic start_bit, cmp_flag, conv_done, cal_busy, busy, rd_valid, rd_ovr;
   logic mux_diff, sample_hold, cmp_hi, cal_mode, sh_q = 0;
   logic [2:0] mux_chan;
   logic [1:0] mux_ch7_sel;
   logic [11:0] rd_data, dac_code, ex [8];
   bit ev [8], eo [8];
   int eq [$], lst [$], n_mismatch = 0, n_checks = 0, k, c;
   logic [2:0] seen [$];
   integer seed = 32'hd8bd;
   // clock
   always #25 clk = ~clk;
   sadc_ctrl u_sadc_ctrl (.clk(clk), .rst(rst), .mode(mode), .start_wr(pls[0]),
      .start_clr(pls[1]), .conversion_start_bit(start_bit), .ext_trig_en(ext_trig_en),
      .external_trigger_pin(pls[5]), .chan_en(chan_en), .single_chan(single_chan),
      .diff_mode(diff_mode), .ch7_src(ch7_src), .cmp_en(cmp_en), .cmp_val(cmp_val),
      .cmp_clr(pls[3]), .cmp_flag(cmp_flag), .done_clr(pls[2]), .conv_done(conv_done),
      .cal_req(pls[4]), .cal_busy(cal_busy), .busy(busy), .rd_en(rd_en), .rd_chan(rd_chan),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_ovr(rd_ovr), .mux_chan(mux_chan),
      .mux_diff(mux_diff), .mux_ch7_sel(mux_ch7_sel), .sample_hold(sample_hold),
      .dac_code(dac_code), .cmp_hi(cmp_hi), .cal_mode(cal_mode));
   sadc_core_model #(.BG(BG), .TP(TP)) u_sadc_core_model (.clk(clk), .volt(volt),
      .mux_chan(mux_chan), .mux_diff(mux_diff), .mux_ch7_sel(mux_ch7_sel),
      .sample_hold(sample_hold), .dac_code(dac_code), .cmp_hi(cmp_hi));
   // record the channel of every sample phase
   always @(posedge clk) begin
      if (sample_hold === 1'b1 && sh_q === 1'b0) seen.push_back(mux_chan);
      sh_q <= sample_hold;
   end
   task automatic chk_bit(input string m, input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error t=%0t %s got %b exp %b", $time, m, g, e);
      end
   endtask : chk_bit
   task automatic chk_val(input string m, input logic [11:0] g, input logic [11:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk_val
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // one-cycle pulse on a strobe input
   task automatic pulse(input int w);
      @(posedge clk) pls[w] <= 1'b1;
      @(posedge clk) pls[w] <= 1'b0;
   endtask : pulse
   task automatic wait_done(output int n);
      n = 0;
      while (conv_done !== 1'b1 && n < 400) begin
         tick(1);
         #1;
         n++;
      end
   endtask : wait_done
   task automatic wait_idle(output int n);
      n = 0;
      while ((busy !== 1'b0 || start_bit !== 1'b0) && n < 2000) begin
         tick(1);
         #1;
         n++;
      end
      if (n >= 2000) begin
         n_mismatch++;
         $display("Error t=%0t idle wait limit reached", $time);
      end
   endtask : wait_idle
   function automatic logic [11:0] src(input int ch);
      if (ch != 7 || ch7_src == CH7_EXT) return volt[ch];
      return ch7_src == CH7_BGAP ? BG : ch7_src == CH7_TEMP ? TP : 12'h000;
   endfunction : src
   // reference model of one stored result
   function automatic void conv(input int ch);
      eo[ch] = eo[ch] | ev[ch];
      ev[ch] = 1;
      ex[ch] = src(ch);
      eq.push_back(ch);
   endfunction : conv
   task automatic chk_order;
      chk_val("count", 12'(seen.size()), 12'(eq.size()));
      while (seen.size() > 0 && eq.size() > 0)
         chk_val("chan", 12'(seen.pop_front()), 12'(eq.pop_front()));
      seen = {};
      eq = {};
   endtask : chk_order
   // read every channel and compare against the model
   task automatic chk_all;
      for (int ch = 0; ch < NCH; ch++) begin
         @(posedge clk);
         rd_en <= 1'b1;
         rd_chan <= 3'(ch);
         @(posedge clk) rd_en <= 1'b0;
         #1;
         chk_bit("valid", rd_valid, ev[ch]);
         chk_bit("ovr", rd_ovr, eo[ch]);
         if (ev[ch]) chk_val("data", rd_data, ex[ch]);
         ev[ch] = 0;
         eo[ch] = 0;
      end
      pulse(2);
   endtask : chk_all
   // one single-mode conversion from start bit or trigger pin
   task automatic single(input int ch, input int w);
      @(posedge clk);
      mode <= MODE_SINGLE;
      single_chan <= 3'(ch);
      if (!cmp_en) begin
         for (int i = 0; i < NCH; i++) volt[i] <= 12'($random(seed));
      end
      pulse(w);
      wait_done(k);
      conv(diff_mode ? ch % 4 : ch);
      chk_bit("done", conv_done, 1'b1);
      tick(1);
      #1;
      chk_bit("start", start_bit, 1'b0);
   endtask : single
   initial begin
      for (int i = 0; i < 8; i++) ev[i] = 0;
      eo = ev;
      tick(5);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         ch7_src <= i > 7 ? 2'(i - 7) : 2'h0;
         single(i > 7 ? 7 : i, 0);
         chk_bit("time", k < CONV_MAX_CYC, 1'b1);
         chk_val("src", 12'(mux_ch7_sel), 12'(ch7_src));
         chk_order();
         chk_all();
      end
      $display("single and channel seven sources done");
      en = 8'($random(seed)) | 8'h10;
      chan_en <= en;
      mode <= MODE_SCAN;
      for (int p = 0; p < 2; p++) begin
         pulse(2);
         pulse(0);
         wait_done(k);
         for (int i = 0; i < NCH; i++) if (en[i]) conv(i);
         chk_bit("scan done", conv_done, 1'b1);
         chk_order();
      end
      chk_all();
      $display("single-cycle scan done");
      mode <= MODE_CONT;
      lst = {};
      for (int i = 0; i < NCH; i++) if (en[i]) lst.push_back(i);
      pulse(0);
      tick(1);
      #1;
      chk_bit("start set", start_bit, 1'b1);
      for (k = 0; k < 2000 && seen.size() < 2 * lst.size() + 1; k++) tick(1);
      chk_bit("passes seen", k < 2000, 1'b1);
      pulse(1);
      wait_idle(k);
      chk_bit("whole passes", seen.size() % lst.size() == 0, 1'b1);
      chk_bit("no done", conv_done, 1'b0);
      for (int i = 0; i < seen.size(); i++) conv(lst[i % lst.size()]);
      chk_order();
      chk_all();
      $display("continuous scan done");
      ext_trig_en <= 1'b1;
      single(2, 5);
      ext_trig_en <= 1'b0;
      chk_order();
      chk_all();
      $display("external trigger done");
      cmp_en <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         c = $random(seed);
         volt[3] <= 12'(c);
         cmp_val <= 12'(c) ^ 12'(i);
         single(3, 0);
         chk_bit("cmp", cmp_flag, i == 0);
         pulse(3);
         chk_order();
         chk_all();
      end
      cmp_en <= 1'b0;
      $display("compare done");
      diff_mode <= 1'b1;
      single(5, 0);
      chk_bit("diff", mux_diff, 1'b1);
      chk_order();
      chk_all();
      diff_mode <= 1'b0;
      $display("differential done");
      pulse(4);
      #1;
      chk_bit("cal", cal_mode & cal_busy, 1'b1);
      wait_idle(k);
      chk_val("cal end", 12'(k), 12'(CAL_CYC));
      $display("calibration done");
      tally_and_finish();
   end
   // watchdog
   initial begin
      #(50 * 20000);
      n_mismatch++;
      $display("Error t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
